//--- pwr_key_reset_ctrl.sv
/*
 * Power-key debounce, hold actions, edge flag and reset-pin control.
 * Assumes the register port is fed by the control interface, the unlock
 * state comes from the security register and the power state from the
 * power-state controller; all inputs are synchronous to mclk.
 */
`timescale 1ns/1ps
module pwr_key_reset_ctrl #(
   parameter int TICK_CYCLES = pwr_key_reset_pkg::TICK_CYCLES,
   parameter int HOLD_UNIT_MS = pwr_key_reset_pkg::HOLD_UNIT_MS
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Register port
   input wire pwr_key_reset_pkg::regReq_s regReq,
   output logic [15:0] regRdata,
   input wire logic userUnlocked,
   // Power-state controller
   input wire pwr_key_reset_pkg::powerState_e powerState,
   input wire logic onSequenceDone,
   output logic keyOnRequest,
   output logic keyOffRequest,
   output logic hwResetRequest,
   output logic keyIrq,
   // Pins
   input wire logic keyPin_n,
   input wire logic resetPinIn,
   output logic resetPinOut,
   output logic resetPinOe,
   output logic auxResetOut
);
   import pwr_key_reset_pkg::*;

   // ****************************************************************
   // Key timing state
   // ****************************************************************
   logic keyRaw, next_keyRaw, keyDeb, next_keyDeb;
   logic [4:0] debCount, next_debCount;
   logic [19:0] tickCount, next_tickCount;
   logic tick, next_tick;
   logic [15:0] holdCount, next_holdCount;
   holdState_e holdState, next_holdState;
   logic keyFall, keyRise, holdExpired, holdFire, thirdFire;
   logic [15:0] holdPeriod;

   // ****************************************************************
   // Register and output state
   // ****************************************************************
   keyCtrl_s keyCtrl, next_keyCtrl;
   resetCtrl_s resetCtrl, next_resetCtrl;
   logic edgeFlag, next_edgeFlag, edgeMask, next_edgeMask;
   logic [15:0] next_regRdata;
   logic next_keyOnRequest, next_keyOffRequest, next_hwResetRequest;
   logic releaseHold, next_releaseHold;
   logic [6:0] releaseCount, next_releaseCount;
   logic next_resetPinOe, next_auxResetOut, drivePrev, next_drivePrev;
   logic extLow, edgeEvent;

   // Address match used by several decoders
   function automatic logic hit(input regReq_s req, input logic [15:0] addr);
      return req.addr == addr;
   endfunction

   // Key edges, hold expiry and fired actions
   assign keyFall = keyDeb & ~next_keyDeb;
   assign keyRise = ~keyDeb & next_keyDeb;
   assign holdPeriod = 16'(HOLD_UNIT_MS) << keyCtrl.holdTimeout;
   assign holdExpired = tick && (holdCount == holdPeriod - 16'h0001);
   assign holdFire = holdExpired && (holdState == HOLD_FIRST);
   assign thirdFire = holdExpired && (holdState == HOLD_SECOND);
   // Guarded sampling: our drive and its release cycle are excluded
   assign extLow = ~resetPinIn & ~resetPinOe & ~drivePrev;
   assign edgeEvent = keyFall | keyRise | (holdFire && keyCtrl.holdAction == ACT_NONE);

   // Millisecond tick, debounce filter and hold sequencing
   always_comb begin
      next_keyRaw = keyPin_n;
      next_tick = 1'b0;
      next_tickCount = tickCount + 20'h00001;
      if (tickCount == 20'(TICK_CYCLES - 1)) begin
         next_tickCount = 20'h00000;
         next_tick = 1'b1;
      end
      next_keyDeb = keyDeb;
      next_debCount = debCount;
      if (keyRaw == keyDeb) begin
         next_debCount = 5'h00;
      end else if (tick) begin
         next_debCount = debCount + 5'h01;
         if (debCount == DEBOUNCE_MS - 5'h01) begin
            next_keyDeb = keyRaw;
            next_debCount = 5'h00;
         end
      end
      next_holdState = holdState;
      next_holdCount = holdCount;
      if (keyFall) begin
         next_holdState = HOLD_FIRST;
         next_holdCount = 16'h0000;
      end else if (next_keyDeb) begin
         next_holdState = HOLD_IDLE;
         next_holdCount = 16'h0000;
      end else if (tick && holdState != HOLD_IDLE && holdState != HOLD_DONE) begin
         next_holdCount = holdExpired ? 16'h0000 : holdCount + 16'h0001;
         case (holdState)
            HOLD_FIRST: begin
               if (holdExpired) begin
                  next_holdState = HOLD_SECOND;
               end
            end
            HOLD_SECOND: begin
               if (holdExpired) begin
                  next_holdState = HOLD_DONE;
               end
            end
            default: begin
               next_holdState = HOLD_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         keyRaw <= 1'b1;
         keyDeb <= 1'b1;
         debCount <= 5'h00;
         tickCount <= 20'h00000;
         tick <= 1'b0;
         holdCount <= 16'h0000;
         holdState <= HOLD_IDLE;
      end else begin
         keyRaw <= next_keyRaw;
         keyDeb <= next_keyDeb;
         debCount <= next_debCount;
         tickCount <= next_tickCount;
         tick <= next_tick;
         holdCount <= next_holdCount;
         holdState <= next_holdState;
      end
   end

   // Register writes, read data and edge flag
   always_comb begin
      next_keyCtrl = keyCtrl;
      next_resetCtrl = resetCtrl;
      next_edgeMask = edgeMask;
      next_edgeFlag = edgeFlag;
      next_regRdata = regRdata;
      if (regReq.write && userUnlocked) begin
         if (hit(regReq, KEY_CTRL_ADDR)) begin
            next_keyCtrl.holdAction = regReq.wdata[KEY_HOLD_ACTION_LSB +: 2];
            next_keyCtrl.firstAction = regReq.wdata[KEY_FIRST_ACTION_LSB +: 2];
            next_keyCtrl.holdTimeout = regReq.wdata[KEY_HOLD_TIMEOUT_LSB +: 2];
         end else if (hit(regReq, RESET_CTRL_ADDR)) begin
            next_resetCtrl.sleepAuxDrive = regReq.wdata[SLEEP_AUX_DRIVE_BIT];
            next_resetCtrl.sleepInputMask = regReq.wdata[SLEEP_INPUT_MASK_BIT];
            next_resetCtrl.sleepDrive = regReq.wdata[SLEEP_DRIVE_BIT];
            next_resetCtrl.releaseDelay = regReq.wdata[RELEASE_DELAY_LSB +: 2];
         end
      end
      if (regReq.write && hit(regReq, FLAGS_ONE_MASK_ADDR)) begin
         next_edgeMask = regReq.wdata[KEY_EDGE_FLAG_BIT];
      end
      // Write-one clears, a same-cycle event wins
      if (regReq.write && hit(regReq, FLAGS_ONE_ADDR) && regReq.wdata[KEY_EDGE_FLAG_BIT]) begin
         next_edgeFlag = 1'b0;
      end
      if (edgeEvent) begin
         next_edgeFlag = 1'b1;
      end
      if (regReq.read) begin
         next_regRdata = 16'h0000;
         if (hit(regReq, KEY_CTRL_ADDR)) begin
            next_regRdata[KEY_HOLD_ACTION_LSB +: 2] = keyCtrl.holdAction;
            next_regRdata[KEY_FIRST_ACTION_LSB +: 2] = keyCtrl.firstAction;
            next_regRdata[KEY_LEVEL_STATUS_BIT] = keyRaw;
            next_regRdata[KEY_HOLD_TIMEOUT_LSB +: 2] = keyCtrl.holdTimeout;
         end else if (hit(regReq, RESET_CTRL_ADDR)) begin
            next_regRdata[SLEEP_AUX_DRIVE_BIT] = resetCtrl.sleepAuxDrive;
            next_regRdata[SLEEP_INPUT_MASK_BIT] = resetCtrl.sleepInputMask;
            next_regRdata[SLEEP_DRIVE_BIT] = resetCtrl.sleepDrive;
            next_regRdata[RELEASE_DELAY_LSB +: 2] = resetCtrl.releaseDelay;
         end else if (hit(regReq, FLAGS_ONE_ADDR)) begin
            next_regRdata[KEY_EDGE_FLAG_BIT] = edgeFlag;
         end else if (hit(regReq, FLAGS_ONE_MASK_ADDR)) begin
            next_regRdata[KEY_EDGE_FLAG_BIT] = edgeMask;
         end
      end
      // External hardware reset returns control state to defaults
      if (next_hwResetRequest) begin
         next_keyCtrl = '{KEY_HOLD_ACTION_RST, KEY_FIRST_ACTION_RST, KEY_HOLD_TIMEOUT_RST};
         next_resetCtrl = '{SLEEP_BIT_RST, SLEEP_BIT_RST, SLEEP_BIT_RST, RELEASE_DELAY_RST};
         next_edgeMask = EDGE_MASK_RST;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         keyCtrl <= '{KEY_HOLD_ACTION_RST, KEY_FIRST_ACTION_RST, KEY_HOLD_TIMEOUT_RST};
         resetCtrl <= '{SLEEP_BIT_RST, SLEEP_BIT_RST, SLEEP_BIT_RST, RELEASE_DELAY_RST};
         edgeMask <= EDGE_MASK_RST;
         edgeFlag <= 1'b0;
         regRdata <= 16'h0000;
      end else begin
         keyCtrl <= next_keyCtrl;
         resetCtrl <= next_resetCtrl;
         edgeMask <= next_edgeMask;
         edgeFlag <= next_edgeFlag;
         regRdata <= next_regRdata;
      end
   end

   // Requests, interrupt and reset-pin drive
   always_comb begin
      next_keyOnRequest = (keyFall && keyCtrl.firstAction == ACT_ON) ||
                          (holdFire && keyCtrl.holdAction == ACT_ON);
      next_keyOffRequest = (keyFall && keyCtrl.firstAction == ACT_OFF) ||
                           (holdFire && keyCtrl.holdAction == ACT_OFF) || thirdFire;
      next_hwResetRequest = extLow && !(powerState == ST_SLEEP && resetCtrl.sleepInputMask);
      next_releaseHold = releaseHold;
      next_releaseCount = releaseCount;
      if (powerState != ST_ON) begin
         next_releaseHold = 1'b1;
         next_releaseCount = 7'h00;
      end else if (onSequenceDone && releaseHold) begin
         next_releaseCount = RELEASE_DELAY_MS[resetCtrl.releaseDelay];
      end else if (tick && releaseCount != 7'h00) begin
         next_releaseCount = releaseCount - 7'h01;
         if (releaseCount == 7'h01) begin
            next_releaseHold = 1'b0;
         end
      end
      next_resetPinOe = (powerState == ST_OFF) ||
                        (powerState == ST_SLEEP && resetCtrl.sleepDrive) ||
                        (powerState == ST_ON && releaseHold);
      next_auxResetOut = (powerState == ST_OFF) ||
                         (powerState == ST_SLEEP && resetCtrl.sleepAuxDrive);
      next_drivePrev = resetPinOe;
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         keyOnRequest <= 1'b0;
         keyOffRequest <= 1'b0;
         hwResetRequest <= 1'b0;
         keyIrq <= 1'b0;
         releaseHold <= 1'b1;
         releaseCount <= 7'h00;
         resetPinOut <= 1'b0;
         resetPinOe <= 1'b1;
         auxResetOut <= 1'b1;
         drivePrev <= 1'b1;
      end else begin
         keyOnRequest <= next_keyOnRequest;
         keyOffRequest <= next_keyOffRequest;
         hwResetRequest <= next_hwResetRequest;
         keyIrq <= edgeFlag & ~edgeMask;
         releaseHold <= next_releaseHold;
         releaseCount <= next_releaseCount;
         resetPinOut <= 1'b0;
         resetPinOe <= next_resetPinOe;
         auxResetOut <= next_auxResetOut;
         drivePrev <= next_drivePrev;
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   a_off_pin_drive: assert property (@(posedge mclk) disable iff (!reset_n)
      powerState == ST_OFF |=> resetPinOe && auxResetOut)
      else $error("reset pin or aux reset not driven in OFF");
   a_edge_flag_set: assert property (@(posedge mclk) disable iff (!reset_n)
      (keyFall || keyRise) |=> edgeFlag)
      else $error("key edge did not set flag");
   a_irq_masking: assert property (@(posedge mclk) disable iff (!reset_n)
      ##1 keyIrq == ($past(edgeFlag) && !$past(edgeMask)))
      else $error("interrupt does not follow flag and mask");
   a_locked_write: assert property (@(posedge mclk) disable iff (!reset_n)
      regReq.write && !userUnlocked && !next_hwResetRequest |=> $stable(keyCtrl) && $stable(resetCtrl))
      else $error("locked field changed");
   a_first_on: assert property (@(posedge mclk) disable iff (!reset_n)
      keyFall && keyCtrl.firstAction == ACT_ON |=> keyOnRequest)
      else $error("first action ON missing");
   a_third_off: assert property (@(posedge mclk) disable iff (!reset_n)
      thirdFire |=> keyOffRequest ##1 !keyOffRequest)
      else $error("fixed OFF request wrong");
   a_release_stop: assert property (@(posedge mclk) disable iff (!reset_n)
      keyRise |=> holdState == HOLD_IDLE && holdCount == 16'h0000)
      else $error("hold sequence kept running after release");
   a_sleep_mask: assert property (@(posedge mclk) disable iff (!reset_n)
      powerState == ST_SLEEP && resetCtrl.sleepInputMask |=> !hwResetRequest)
      else $error("masked external reset acted in SLEEP");
   a_own_drive_guard: assert property (@(posedge mclk) disable iff (!reset_n)
      hwResetRequest |-> !$past(resetPinOe, 1) && !$past(resetPinOe, 2))
      else $error("own drive seen as external reset");
   a_delay_holds: assert property (@(posedge mclk) disable iff (!reset_n)
      powerState == ST_ON && releaseHold |=> resetPinOe)
      else $error("reset released before delay ended");
endmodule

//--- pwr_key_reset_pkg.sv
/*
 * Constants, field layouts and carrier types for the power-key and
 * reset-pin controller.
 * Assumes a 100 MHz always-on clock and 16-bit registers.
 */
package pwr_key_reset_pkg;
   // ****************************************************************
   // Register offsets
   // ****************************************************************
   localparam logic [15:0] KEY_CTRL_ADDR = 16'h4005;
   localparam logic [15:0] RESET_CTRL_ADDR = 16'h4006;
   localparam logic [15:0] FLAGS_ONE_ADDR = 16'h4011;
   localparam logic [15:0] FLAGS_ONE_MASK_ADDR = 16'h4019;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int KEY_HOLD_ACTION_LSB = 8;
   localparam int KEY_FIRST_ACTION_LSB = 4;
   localparam int KEY_LEVEL_STATUS_BIT = 3;
   localparam int KEY_HOLD_TIMEOUT_LSB = 0;
   localparam int SLEEP_AUX_DRIVE_BIT = 6;
   localparam int SLEEP_INPUT_MASK_BIT = 5;
   localparam int SLEEP_DRIVE_BIT = 4;
   localparam int RELEASE_DELAY_LSB = 0;
   localparam int KEY_EDGE_FLAG_BIT = 12;

   // ****************************************************************
   // Values after reset and action codes
   // ****************************************************************
   localparam logic [1:0] KEY_HOLD_ACTION_RST = 2'h1;
   localparam logic [1:0] KEY_FIRST_ACTION_RST = 2'h0;
   localparam logic [1:0] KEY_HOLD_TIMEOUT_RST = 2'h0;
   localparam logic [1:0] RELEASE_DELAY_RST = 2'h3;
   localparam logic SLEEP_BIT_RST = 1'b1;
   localparam logic EDGE_MASK_RST = 1'b1;
   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_ON = 2'h1;
   localparam logic [1:0] ACT_OFF = 2'h2;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_TIME_NS = 1000000;
   localparam int TICK_CYCLES = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_UNIT_MS = 1000;
   localparam logic [4:0] DEBOUNCE_MS = 5'h14;
   localparam logic [6:0] RELEASE_DELAY_MS [4] = '{7'h03, 7'h0B, 7'h33, 7'h65};

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [2:0] {ST_OFF = 3'b001, ST_SLEEP = 3'b010, ST_ON = 3'b100} powerState_e;
   typedef enum logic [3:0] {
      HOLD_IDLE = 4'b0001, HOLD_FIRST = 4'b0010, HOLD_SECOND = 4'b0100, HOLD_DONE = 4'b1000
   } holdState_e;
   typedef struct packed {
      logic [1:0] holdAction;
      logic [1:0] firstAction;
      logic [1:0] holdTimeout;
   } keyCtrl_s;
   typedef struct packed {
      logic sleepAuxDrive;
      logic sleepInputMask;
      logic sleepDrive;
      logic [1:0] releaseDelay;
   } resetCtrl_s;
   typedef struct packed {
      logic write;
      logic read;
      logic [15:0] addr;
      logic [15:0] wdata;
   } regReq_s;
endpackage

//--- key_reset_partner.sv
/*
 * Far-side model: the user's power switch and a reset-sharing device.
 * Assumes the bench drives the press and external pull requests at mclk edges.
 */
`timescale 1ns/1ps
module key_reset_partner (
   // Scenario controls
   input wire logic pressed,
   input wire logic extPull,
   // Device pins
   input wire logic resetPinOut,
   input wire logic resetPinOe,
   output logic keyPin_n,
   output logic resetPinIn
);
   // Switch shorts the key line to ground, pull-up holds it high otherwise
   assign keyPin_n = pressed ? 1'b0 : 1'b1;
   // Wired-low reset line: pull-up unless either party pulls it down
   assign resetPinIn = ((resetPinOe && !resetPinOut) || extPull) ? 1'b0 : 1'b1;
endmodule

//--- tb_pwr_key_reset_ctrl.sv
/*
 * Self-checking bench for the power-key and reset-pin controller.
 * Assumes short tick and hold-unit parameters so that the run stays brief.
 */
`timescale 1ns/1ps
module tb_pwr_key_reset_ctrl;
   import pwr_key_reset_pkg::*;
   logic mclk, reset_n, userUnlocked, onSequenceDone, pressed, extPull;
   logic keyOnRequest, keyOffRequest, hwResetRequest, keyIrq, keyPin_n, resetPinIn, resetPinOut, resetPinOe;
   logic auxResetOut;
   logic [15:0] regRdata, rd;
   logic [1:0] code;
   regReq_s regReq;
   powerState_e powerState;
   int mismatches = 0, testsRun = 0, onCount = 0, offCount = 0, cycles = 0, seed = 26, on0, off0;
   int hwCount = 0, hw0;

   // ****************************************************************
   // Design, far side and clock
   // ****************************************************************
   pwr_key_reset_ctrl #(.TICK_CYCLES(4), .HOLD_UNIT_MS(8)) pwr_key_reset_ctrl_inst (
      .mclk(mclk), .reset_n(reset_n), .regReq(regReq), .regRdata(regRdata), .userUnlocked(userUnlocked),
      .powerState(powerState), .onSequenceDone(onSequenceDone), .keyOnRequest(keyOnRequest),
      .keyOffRequest(keyOffRequest), .hwResetRequest(hwResetRequest), .keyIrq(keyIrq), .keyPin_n(keyPin_n),
      .resetPinIn(resetPinIn), .resetPinOut(resetPinOut), .resetPinOe(resetPinOe), .auxResetOut(auxResetOut));
   key_reset_partner key_reset_partner_inst (.pressed(pressed), .extPull(extPull), .resetPinOut(resetPinOut),
      .resetPinOe(resetPinOe), .keyPin_n(keyPin_n), .resetPinIn(resetPinIn));
   // Free-running 100 MHz clock
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // ****************************************************************
   // Helpers
   // ****************************************************************
   // Counts request pulses, notes reset requests and cuts a hang short
   always @(posedge mclk) begin
      cycles++;
      if (keyOnRequest === 1'b1) onCount++;
      if (keyOffRequest === 1'b1) offCount++;
      if (hwResetRequest === 1'b1) hwCount++;
      if (cycles == 20000) begin
         mismatches++;
         final_report();
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      testsRun++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic regWrite(input logic [15:0] a, input logic [15:0] d);
      @(posedge mclk);
      regReq <= '{1'b1, 1'b0, a, d};
      @(posedge mclk);
      regReq <= '0;
   endtask
   task automatic regRead(input logic [15:0] a);
      @(posedge mclk);
      regReq <= '{1'b0, 1'b1, a, 16'h0000};
      @(posedge mclk);
      regReq <= '0;
      cyc(1);
      rd = regRdata;
   endtask
   task automatic drive(input int n, input logic p, input logic x);
      @(posedge mclk);
      pressed <= p;
      extPull <= x;
      cyc(n);
   endtask
   // Pulses expected from a first-action code
   function automatic logic [15:0] expPulse(input logic [1:0] c, input logic [1:0] act);
      return (c == act) ? 16'h0001 : 16'h0000;
   endfunction
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", testsRun, mismatches);
      if (mismatches == 0 && testsRun > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   // Main sequence
   initial begin
      regReq = '0;
      userUnlocked = 1'b0;
      powerState = ST_OFF;
      onSequenceDone = 1'b0;
      pressed = 1'b0;
      extPull = 1'b0;
      reset_n = 1'b0;
      repeat (10) @(posedge mclk);
      reset_n <= 1'b1;
      regRead(KEY_CTRL_ADDR); check(rd, 16'h0108, "key control default");
      regRead(RESET_CTRL_ADDR); check(rd, 16'h0073, "reset control default");
      regRead(FLAGS_ONE_ADDR); check(rd, 16'h0000, "flag default");
      regRead(FLAGS_ONE_MASK_ADDR); check(rd, 16'h1000, "mask default");
      regRead(16'h4007); check(rd, 16'h0000, "unmapped read");
      regWrite(KEY_CTRL_ADDR, 16'h0010);
      regRead(KEY_CTRL_ADDR); check(rd, 16'h0108, "locked write");
      $display("Test defaults done");
      // Long press: first ON, hold OFF at two-unit timeout, then fixed OFF
      @(posedge mclk);
      userUnlocked <= 1'b1;
      regWrite(KEY_CTRL_ADDR, 16'h0211);
      on0 = onCount;
      off0 = offCount;
      drive(100, 1'b1, 1'b0);
      check(16'(onCount - on0), 16'h0001, "first action");
      check(16'(offCount - off0), 16'h0000, "no early hold");
      regRead(KEY_CTRL_ADDR); check(rd & 16'h0008, 16'h0000, "key level pressed");
      cyc(70); check(16'(offCount - off0), 16'h0001, "hold action");
      cyc(70); check(16'(offCount - off0), 16'h0002, "fixed off");
      cyc(150); check(16'(offCount - off0), 16'h0002, "no further action");
      drive(150, 1'b0, 1'b0);
      check(16'(onCount - on0), 16'h0001, "no action on release");
      $display("Test hold sequence done");
      // Hold action set to interrupt raises the edge flag again, fixed OFF still follows
      regWrite(KEY_CTRL_ADDR, 16'h0000);
      on0 = onCount;
      off0 = offCount;
      drive(100, 1'b1, 1'b0);
      regWrite(FLAGS_ONE_ADDR, 16'h1000);
      cyc(20);
      regRead(FLAGS_ONE_ADDR); check(rd, 16'h1000, "hold interrupt");
      drive(150, 1'b0, 1'b0);
      check(16'(offCount - off0), 16'h0001, "fixed off after interrupt");
      check(16'(onCount - on0), 16'h0000, "first action ignored");
      $display("Test hold interrupt done");
      // Short press is filtered out
      regWrite(FLAGS_ONE_ADDR, 16'h1000);
      drive(40, 1'b1, 1'b0);
      drive(100, 1'b0, 1'b0);
      regRead(FLAGS_ONE_ADDR); check(rd, 16'h0000, "glitch filtered");
      $display("Test short press done");
      // Random first-action codes with presses shorter than the eight-unit timeout
      for (int i = 0; i < 6; i++) begin
         code = 2'($random(seed));
         regWrite(FLAGS_ONE_ADDR, 16'h1000);
         regWrite(KEY_CTRL_ADDR, {8'h01, 2'b00, code, 4'h3});
         on0 = onCount;
         off0 = offCount;
         drive(95 + ($unsigned($random(seed)) % 10), 1'b1, 1'b0);
         drive(120, 1'b0, 1'b0);
         check(16'(onCount - on0), expPulse(code, ACT_ON), "first action on");
         check(16'(offCount - off0), expPulse(code, ACT_OFF), "first action off");
         regRead(FLAGS_ONE_ADDR); check(rd, 16'h1000, "edge flag");
      end
      $display("Test first actions done");
      // Mask, forward and write-one clear of the edge flag
      check(16'(keyIrq), 16'h0000, "masked flag");
      regWrite(FLAGS_ONE_MASK_ADDR, 16'h0000);
      cyc(3); check(16'(keyIrq), 16'h0001, "unmasked flag");
      regWrite(FLAGS_ONE_ADDR, 16'h1000);
      cyc(3); check(16'(keyIrq), 16'h0000, "flag cleared");
      $display("Test interrupt done");
      // Reset pin in OFF and SLEEP, then external reset paths
      cyc(3); check({resetPinOe, resetPinOut, auxResetOut, hwCount != 0}, 16'h000A, "off drive");
      @(posedge mclk);
      powerState <= ST_SLEEP;
      cyc(3); check({resetPinOe, resetPinOut, auxResetOut}, 16'h0005, "sleep default");
      regWrite(RESET_CTRL_ADDR, 16'h0000);
      cyc(3); check({resetPinOe, auxResetOut}, 16'h0000, "sleep released");
      hw0 = hwCount;
      drive(6, 1'b0, 1'b1);
      check(16'(hwCount != hw0), 16'h0001, "sleep reset unmasked");
      drive(3, 1'b0, 1'b0);
      regRead(RESET_CTRL_ADDR); check(rd, 16'h0073, "registers restored");
      regWrite(RESET_CTRL_ADDR, 16'h0020);
      hw0 = hwCount;
      drive(8, 1'b0, 1'b1);
      check(16'(hwCount != hw0), 16'h0000, "sleep reset masked");
      drive(3, 1'b0, 1'b0);
      $display("Test sleep reset done");
      // Release delay after the ON sequence completes
      @(posedge mclk);
      powerState <= ST_ON;
      regWrite(RESET_CTRL_ADDR, 16'h0000);
      cyc(5); check(16'(resetPinOe), 16'h0001, "held before done");
      @(posedge mclk);
      onSequenceDone <= 1'b1;
      @(posedge mclk);
      onSequenceDone <= 1'b0;
      cyc(5); check(16'(resetPinOe), 16'h0001, "delay running");
      cyc(15); check(16'(resetPinOe), 16'h0000, "released");
      hw0 = hwCount;
      drive(6, 1'b0, 1'b1);
      check(16'(hwCount != hw0), 16'h0001, "external reset in on");
      drive(3, 1'b0, 1'b0);
      $display("Test reset pin done");
      final_report();
   end
endmodule
